// file: inc/quad_pkg.sv
/*
 * Constants and carrier types for the quadrature and reference-mark output logic.
 * Assumes one clock domain and an interpolated position already in step units.
 */
package quad_pkg;

	// ------------------------------------------------------------
	// Geometry of one pole pair
	// ------------------------------------------------------------
	localparam logic [7:0] STEPS_PER_PAIR = 8'ha0; // 160 steps per pole pair
	localparam logic [7:0] HALF_PAIR = 8'h50; // Splits forward from backward distance
	localparam logic [7:0] ZERO_STEP = 8'h00; // Step holding the reference mark
	localparam logic [7:0] LAST_STEP = 8'h9f; // Step just before wrap
	localparam logic [7:0] HYST_STEPS = 8'h02; // Steps needed to reverse direction
	localparam logic [1:0] GRAY_OFFSET = 2'h2; // Puts A=B=1 on the zero step

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] pos; // Interpolated position, 0 to 159
		logic low_field; // Field too weak to trust the position
	} sense_s;

	typedef struct packed {
		logic a; // Quadrature output A
		logic b; // Quadrature output B
		logic mark; // Reference mark, active high
	} quad_out_s;

	typedef struct packed {
		logic [7:0] step; // Step now shown on the outputs
		logic dir_fwd; // Direction of the last step taken
		logic loaded; // Step was seeded from the input
		quad_out_s out; // Registered pin levels
	} quad_state_s;

endpackage : quad_pkg

// file: logic/quad_index_out.sv
/*
 * Quadrature A/B and reference-mark output stage of a magnetic position sensor.
 * Assumes pos and low_field are synchronous to mclk and pos moves slowly against the clock.
 */
`timescale 1ns/100ps

module quad_index_out (
	input wire logic mclk, // 125 MHz clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire quad_pkg::sense_s sense, // Position and field condition
	input wire logic zero_mask_test_in, // Test input, high hides the mark
	output quad_pkg::quad_out_s quad_out // Registered A, B and mark
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Forward distance from step to pos, modulo one pole pair
	function automatic logic [7:0] fwd_dist(input logic [7:0] pos, input logic [7:0] step);
		logic [7:0] d;
		d = 8'h00;
		if (pos >= step)
			d = pos - step;
		else
			d = pos + (quad_pkg::STEPS_PER_PAIR - step);
		return d;
	endfunction : fwd_dist

	// A/B levels for a step; 40 gray cycles per pair, A leads on increase
	function automatic logic [1:0] gray_ab(input logic [7:0] step);
		logic [1:0] s;
		s = step[1:0] + quad_pkg::GRAY_OFFSET;
		return {s[1] ^ s[0], s[1]}; // {A, B}
	endfunction : gray_ab

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	quad_pkg::quad_state_s st_reg; // All registered state
	quad_pkg::quad_state_s st_next; // Its next value
	logic [7:0] ahead; // Steps the input is ahead
	logic [7:0] behind; // Steps the input is behind
	logic pos_ok; // Input lies inside one pair

	// Distances are taken modulo one pole pair so the wrap is seamless
	assign pos_ok = sense.pos < quad_pkg::STEPS_PER_PAIR;
	assign ahead = fwd_dist(sense.pos, st_reg.step);
	assign behind = quad_pkg::STEPS_PER_PAIR - ahead;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------

	// Step follows the input one step per clock so the host never misses an edge
	always_comb
	begin
		logic [1:0] ab;
		ab = 2'h0;
		st_next = st_reg;
		if (!st_reg.loaded)
		begin
			// First valid sample seeds the step; pins jump straight to its A/B levels without stepping
			if (pos_ok && !sense.low_field)
			begin
				st_next.step = sense.pos;
				st_next.loaded = 1'b1;
			end
		end
		else if (pos_ok && !sense.low_field && ahead != quad_pkg::ZERO_STEP)
		begin
			if (ahead < quad_pkg::HALF_PAIR)
			begin
				// Reversal waits for extra travel so boundary noise is ignored
				if (st_reg.dir_fwd || ahead >= quad_pkg::HYST_STEPS)
				begin
					st_next.dir_fwd = 1'b1;
					if (st_reg.step == quad_pkg::LAST_STEP)
						st_next.step = quad_pkg::ZERO_STEP;
					else
						st_next.step = st_reg.step + 8'h01;
				end
			end
			else if (!st_reg.dir_fwd || behind >= quad_pkg::HYST_STEPS)
			begin
				st_next.dir_fwd = 1'b0;
				if (st_reg.step == quad_pkg::ZERO_STEP)
					st_next.step = quad_pkg::LAST_STEP;
				else
					st_next.step = st_reg.step - 8'h01;
			end
		end
		ab = gray_ab(st_next.step);
		if (sense.low_field)
		begin
			// Warning pattern that normal motion never produces
			st_next.out.a = 1'b0;
			st_next.out.b = 1'b0;
			st_next.out.mark = 1'b1;
		end
		else if (!st_next.loaded)
		begin
			// Quiet until a position has been seen
			st_next.out.a = 1'b0;
			st_next.out.b = 1'b0;
			st_next.out.mark = 1'b0;
		end
		else
		begin
			st_next.out.a = ab[1];
			st_next.out.b = ab[0];
			// Mark spans exactly the zero step
			st_next.out.mark = (st_next.step == quad_pkg::ZERO_STEP)
				&& !zero_mask_test_in;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------

	// Reset holds outputs low and forces a fresh seed
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// Pins come straight from the state register, never through logic
	assign quad_out = st_reg.out;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// All checks sample on mclk and rest while rst_n is low
	// Pins lag the inputs by one clock, so pin checks read $past(sense.low_field)
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic normal_now; // Pins differ from the warning pattern
	// Warning pattern is reserved, so no tracked step may ever produce it
	assign normal_now = !st_reg.out.mark || st_reg.out.a || st_reg.out.b;

	// Warning pattern only ever means a weak field
	a_no_false_warn: assert property (!$past(sense.low_field) |-> normal_now)
		else $error("warning pattern without weak field");

	// Out-of-range positions must never move the step
	a_range_hold: assert property (st_reg.loaded && !pos_ok
		|=> st_reg.step == $past(st_reg.step))
		else $error("step moved on an out-of-range position");

	a_step_range: assert property (st_reg.step < quad_pkg::STEPS_PER_PAIR)
		else $error("step left the pole pair");

	a_one_edge: assert property (
		$past(st_reg.loaded) && !$past(sense.low_field) && !sense.low_field && $past(rst_n)
		&& $past(!sense.low_field, 2)
		|=> !(($past(quad_out.a) != quad_out.a) && ($past(quad_out.b) != quad_out.b)))
		else $error("A and B changed together");

	a_fwd_lead: assert property (
		st_reg.loaded && !$past(sense.low_field) && st_reg.dir_fwd
		&& st_reg.step != $past(st_reg.step) && $past(st_reg.loaded)
		|-> {quad_out.a, quad_out.b} == gray_ab(st_reg.step)
		&& st_reg.step == fwd_dist($past(st_reg.step) + 8'h01, 8'h00) % quad_pkg::STEPS_PER_PAIR)
		else $error("forward step did not advance by one");

	a_low_warn: assert property ($past(sense.low_field) |-> quad_out.mark && !quad_out.a
		&& !quad_out.b)
		else $error("low field pattern missing");

	a_mark_zero: assert property (quad_out.mark && !$past(sense.low_field)
		|-> st_reg.step == quad_pkg::ZERO_STEP)
		else $error("mark high away from zero step");

	a_mark_drop: assert property (quad_out.mark && !$past(sense.low_field)
		##1 st_reg.step != quad_pkg::ZERO_STEP && !$past(sense.low_field)
		|-> !quad_out.mark)
		else $error("mark outlived the zero step");

	a_zero_combo: assert property (st_reg.loaded && !$past(sense.low_field)
		&& st_reg.step == quad_pkg::ZERO_STEP |-> quad_out.a && quad_out.b)
		else $error("zero step without A and B high");

	a_zero_mark: assert property (st_reg.loaded && !$past(sense.low_field)
		&& !$past(zero_mask_test_in) && st_reg.step == quad_pkg::ZERO_STEP |-> quad_out.mark)
		else $error("zero step without mark");

	a_reverse_hyst: assert property (
		$past(rst_n) && $past(st_reg.loaded) && $past(st_reg.dir_fwd) != st_reg.dir_fwd
		|-> $past(st_reg.dir_fwd) ? $past(behind) >= quad_pkg::HYST_STEPS
		: $past(ahead) >= quad_pkg::HYST_STEPS)
		else $error("direction reversed inside hysteresis");

	a_quarter_phase: assert property (st_reg.loaded && !$past(sense.low_field)
		|-> {quad_out.a, quad_out.b} == gray_ab(st_reg.step))
		else $error("A/B not in quarter phase with step");

	// Lead checks compare only the pins, not gray_ab, so a wrong Gray table shows up here
	// Forward: A toggles exactly when the new A and B differ
	a_fwd_edge: assert property (st_reg.dir_fwd && $past(st_reg.loaded)
		&& st_reg.loaded && st_reg.step != $past(st_reg.step) && !$past(sense.low_field, 2)
		|-> (quad_out.a != $past(quad_out.a)) == (quad_out.a != quad_out.b))
		else $error("forward step not led by A");

	// Backward: A toggles exactly when the new A and B agree, so B leads
	a_rev_edge: assert property (!st_reg.dir_fwd && $past(st_reg.loaded)
		&& st_reg.loaded && st_reg.step != $past(st_reg.step) && !$past(sense.low_field, 2)
		|-> (quad_out.a != $past(quad_out.a)) == (quad_out.a == quad_out.b))
		else $error("backward step not led by B");

endmodule : quad_index_out

// file: tb/quad_host_model.sv
/*
 * Host side model: a quadrature counter with reference-mark detection.
 * Assumes the sensor pins are sampled on the same mclk as the design.
 */
`timescale 1ns/100ps

module quad_host_model (
	input wire logic mclk, // Shared clock
	input wire logic rst_n, // Clears the counters
	input wire quad_pkg::quad_out_s quad_out, // Pins from the sensor
	output int count, // Signed edge count
	output int marks, // Marks seen with A=B=1
	output int bad // Double changes seen
);
	logic [1:0] g_reg; // Last normal Gray code
	logic mark_reg; // Last normal mark level
	logic [1:0] g; // Gray code of the pins
	logic lowf; // Warning combination present
	assign g = {quad_out.b, quad_out.a ^ quad_out.b};
	assign lowf = quad_out.mark & ~quad_out.a & ~quad_out.b;

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// Warning states are skipped, so a frozen step resumes without a count
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			count <= 0;
			marks <= 0;
			bad <= 0;
			g_reg <= 2'h0;
			mark_reg <= 1'b0;
		end
		else if (!lowf)
		begin
			if (g == g_reg + 2'h1) count <= count + 1;
			else if (g == g_reg - 2'h1) count <= count - 1;
			else if (g != g_reg) bad <= bad + 1;
			if (quad_out.mark && !mark_reg && quad_out.a && quad_out.b) marks <= marks + 1;
			g_reg <= g;
			mark_reg <= quad_out.mark;
		end
	end
endmodule : quad_host_model

// file: tb/tb_quad_index_out.sv
/*
 * Testbench for the quadrature and reference-mark output stage.
 * Assumes one-cycle output latency and one step per cycle toward pos.
 */
`timescale 1ns/100ps

module tb_quad_index_out;
	logic mclk = 1'b0; // 125 MHz clock
	logic rst_n = 1'b0; // Reset, active low
	quad_pkg::sense_s sense = '0; // Position and field
	logic zero_mask_test_in = 1'b0; // Test input, high hides the mark
	quad_pkg::quad_out_s quad_out; // Pins
	int count, marks, bad, error_cnt, checks_done, c0, m0, b0;

	initial forever #4 mclk = ~mclk;

	quad_index_out quad_index_out_inst (.mclk(mclk), .rst_n(rst_n), .sense(sense),
		.zero_mask_test_in(zero_mask_test_in), .quad_out(quad_out));
	quad_host_model quad_host_model_inst (.mclk(mclk), .rst_n(rst_n), .quad_out(quad_out),
		.count(count), .marks(marks), .bad(bad));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task chk(input bit ok, input string msg);
		checks_done++;
		if (!ok)
		begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	task stop_test;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// One full pole pair forward, wrapping back onto the zero step
	task t_forward;
		c0 = count;
		m0 = marks;
		b0 = bad;
		for (int i = 1; i <= 160; i++)
		begin
			sense.pos = 8'(i % 160);
			tick(1);
		end
		tick(3);
		chk(count - c0 == 160, "forward edge count");
		chk(marks - m0 == 1, "one mark per pair");
		chk(bad == b0, "double change");
		chk(quad_out === 3'h7, "zero step pins");
	endtask : t_forward

	// Step off zero, a one-step reversal that must be ignored, then back
	task t_reverse;
		sense.pos = 8'h01;
		tick(3);
		chk(quad_out === 3'h2, "mark one step off");
		c0 = count;
		sense.pos = 8'h00;
		tick(3);
		chk(quad_out === 3'h2 && count == c0, "reversal hysteresis");
		sense.pos = 8'h96;
		tick(20);
		chk(count - c0 == -11 && quad_out === 3'h0, "backward travel");
	endtask : t_reverse

	// Weak field shows the warning, then the frozen step returns
	task t_low_field;
		c0 = count;
		sense.low_field = 1'b1;
		tick(2);
		chk(quad_out === 3'h1, "low field warning");
		sense.low_field = 1'b0;
		tick(2);
		chk(quad_out === 3'h0 && count == c0, "resume after warning");
		sense.pos = 8'ha0;
		tick(3);
		chk(quad_out === 3'h0 && count == c0, "out-of-range position");
	endtask : t_low_field

	// Test input hides the mark at zero, then the mark comes back
	task t_mask;
		c0 = count;
		m0 = marks;
		zero_mask_test_in = 1'b1;
		sense.pos = 8'h00;
		tick(14);
		chk(quad_out === 3'h6 && count - c0 == 10, "masked zero step");
		chk(marks == m0, "mark seen while masked");
		zero_mask_test_in = 1'b0;
		tick(2);
		chk(quad_out === 3'h7 && marks - m0 == 1, "mark after unmask");
	endtask : t_mask

	// Reset in mid-run clears the pins, then a new seed shows its own step
	task t_reset;
		rst_n = 1'b0;
		sense.pos = 8'h03;
		tick(2);
		chk(quad_out === 3'h0, "pins low in reset");
		rst_n = 1'b1;
		tick(2);
		chk(quad_out === 3'h4, "reseed after reset");
	endtask : t_reset

	initial
	begin
		tick(19);
		chk(quad_out === 3'h0, "outputs in reset");
		tick(1);
		rst_n = 1'b1;
		tick(3);
		chk(quad_out === 3'h7, "seed at zero");
		t_forward();
		t_reverse();
		t_low_field();
		t_mask();
		t_reset();
		stop_test();
	end

	// Whole run is under 300 cycles
	initial
	begin
		#20000;
		error_cnt++;
		stop_test();
	end
endmodule : tb_quad_index_out
